// >>> hw/tio_pkg.sv
// Package for the trigger input and event output block.
// Assumes a single 50 MHz clock and an AXI4-Lite register slave.
package tio_pkg;
	localparam int unsigned CLK_HZ = 50000000;
	localparam int unsigned TICK_MS = 1;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_IN0 = 8'h04;
	localparam logic [7:0] ADDR_IN1 = 8'h08;
	localparam logic [7:0] ADDR_OUT0 = 8'h0C;
	localparam logic [7:0] ADDR_OUT1 = 8'h10;
	localparam logic [7:0] ADDR_STAT = 8'h14;
	localparam logic [7:0] ADDR_IRQ = 8'h18;
	localparam logic [7:0] ADDR_MASK = 8'h1C;
	localparam logic [7:0] ADDR_RES = 8'h20;
	localparam logic [7:0] DEBOUNCE_RST = 8'h02;
	localparam logic [15:0] DURATION_RST = 16'h0064;
	localparam logic [15:0] DELAY_RST = 16'h0064;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {POL_NONE, POL_RISE, POL_FALL, POL_LOW, POL_HIGH} tio_pol_t;
	typedef enum logic [1:0] {MODE_INTERNAL, MODE_SINGLE, MODE_MULTI, MODE_REPEAT} tio_mode_t;
	typedef enum logic [2:0] {EV_OFF, EV_ON, EV_SUCCESS, EV_FAULT, EV_MISS} tio_ev_t;
endpackage : tio_pkg

// >>> hw/tio_top.sv
// Trigger input conditioning, acquisition window control and event outputs.
// Assumes synchronous AXI4-Lite master and decoder results from the decode core.
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
module tio_top #(
	parameter int unsigned TICK_CYCLES = tio_pkg::TICK_CYCLES,
	parameter int unsigned NUM_TYPES = 4
) (
	input wire logic CLOCK,
	input wire logic RST_B,
	input wire logic [1:0] TRIG_IN,
	input wire logic [NUM_TYPES-1:0] DEC_OK,
	input wire logic DEC_DONE,
	input wire logic DEC_ERR,
	output logic ACQ_ACTIVE,
	output logic [1:0] EVT_OUT,
	output logic IRQ,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic addr_ok(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= tio_pkg::ADDR_RES);
	endfunction : addr_ok

	// Registers: ctrl holds mode[1:0] and read timeout ms [31:16].
	// Output cfg holds source[2:0], duration ms [15:4] and delay ms [31:16]; the duration
	// field is 12 bits so that the source code never overlaps it.
	logic [31:0] ctrl_q, ctrl_d;
	logic [31:0] in_cfg_q [2];
	logic [31:0] in_cfg_d [2];
	logic [31:0] out_cfg_q [2];
	logic [31:0] out_cfg_d [2];
	logic [3:0] irq_st_q, irq_st_d;
	logic [3:0] mask_q, mask_d;
	logic [NUM_TYPES-1:0] sel_q, sel_d;
	logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic arready_q, arready_d;

	// Millisecond tick.
	logic [31:0] tick_cnt_q, tick_cnt_d;
	logic tick;
	// Input path.
	logic [1:0] sync1_q, sync2_q, filt_q, filt_d, filt_prev_q;
	logic [7:0] deb_cnt_q [2];
	logic [7:0] deb_cnt_d [2];
	// Acquisition.
	logic acq_q, acq_d, level_src_q, level_src_d;
	logic [15:0] acq_ms_q, acq_ms_d;
	logic [1:0] ev_pulse_q, ev_pulse_d;
	logic success_q, success_d, fault_q, fault_d, miss_q, miss_d;
	// Outputs.
	logic [1:0] pend_q, pend_d, out_q, out_d;
	logic [15:0] otim_q [2];
	logic [15:0] otim_d [2];

	logic wr_fire, rd_fire, good, trig_start, trig_stop;
	logic [1:0] trig_act, trig_lvl;

	assign tick = (tick_cnt_q == TICK_CYCLES - 1);
	assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
	assign rd_fire = S_AXI_ARVALID && arready_q && !rvalid_q;
	assign good = DEC_DONE && ((DEC_OK & sel_q) == sel_q) && (sel_q != '0);

	always_comb begin
		tick_cnt_d = tick ? 32'h0 : tick_cnt_q + 32'h1;
	end

	always_comb begin
		filt_d = filt_q;
		trig_act = 2'h0;
		trig_lvl = 2'h0;
		for (int i = 0; i < 2; i++) begin
			// The filter needs a stable level for the full debounce count of ms ticks.
			deb_cnt_d[i] = deb_cnt_q[i];
			if (sync2_q[i] == filt_q[i]) begin
				deb_cnt_d[i] = 8'h0;
			end else if (tick) begin
				if (deb_cnt_q[i] + 8'h1 >= in_cfg_q[i][15:8]) begin
					filt_d[i] = sync2_q[i];
					deb_cnt_d[i] = 8'h0;
				end else begin
					deb_cnt_d[i] = deb_cnt_q[i] + 8'h1;
				end
			end
			case (tio_pkg::tio_pol_t'(in_cfg_q[i][2:0]))
				tio_pkg::POL_RISE: trig_act[i] = filt_q[i] && !filt_prev_q[i];
				tio_pkg::POL_FALL: trig_act[i] = !filt_q[i] && filt_prev_q[i];
				tio_pkg::POL_LOW: begin
					trig_act[i] = !filt_q[i] && filt_prev_q[i];
					trig_lvl[i] = !filt_q[i];
				end
				tio_pkg::POL_HIGH: begin
					trig_act[i] = filt_q[i] && !filt_prev_q[i];
					trig_lvl[i] = filt_q[i];
				end
				default: begin
					trig_act[i] = 1'b0;
					trig_lvl[i] = 1'b0;
				end
			endcase
		end
	end

	assign trig_start = (|trig_act) && (ctrl_q[1:0] != 2'h0);
	assign trig_stop = level_src_q && !(|trig_lvl);

	always_comb begin
		acq_d = acq_q;
		level_src_d = level_src_q;
		acq_ms_d = acq_ms_q;
		ev_pulse_d = 2'h0;
		success_d = 1'b0;
		fault_d = 1'b0;
		miss_d = 1'b0;
		if (!acq_q) begin
			if (trig_start) begin
				acq_d = 1'b1;
				level_src_d = |trig_lvl;
				acq_ms_d = 16'h0;
			end
		end else begin
			if (tick) begin
				acq_ms_d = acq_ms_q + 16'h1;
			end
			if (good) begin
				acq_d = 1'b0;
				success_d = 1'b1;
			end else if (DEC_ERR && tio_pkg::tio_mode_t'(ctrl_q[1:0]) != tio_pkg::MODE_REPEAT) begin
				acq_d = 1'b0;
				fault_d = 1'b1;
			end else if (trig_stop || (!level_src_q && tick && acq_ms_q + 16'h1 >= ctrl_q[31:16])) begin
				acq_d = 1'b0;
				miss_d = 1'b1;
			end else if (DEC_ERR) begin
				fault_d = 1'b1;
			end
		end
		ev_pulse_d = 2'h0;
	end

	always_comb begin
		pend_d = pend_q;
		out_d = out_q;
		for (int i = 0; i < 2; i++) begin
			otim_d[i] = otim_q[i];
			case (tio_pkg::tio_ev_t'(out_cfg_q[i][2:0]))
				tio_pkg::EV_ON: begin
					out_d[i] = 1'b1;
					pend_d[i] = 1'b0;
				end
				tio_pkg::EV_SUCCESS, tio_pkg::EV_FAULT, tio_pkg::EV_MISS: begin
					if ((out_cfg_q[i][2:0] == 3'h2 && success_q) ||
						(out_cfg_q[i][2:0] == 3'h3 && fault_q) ||
						(out_cfg_q[i][2:0] == 3'h4 && miss_q)) begin
						pend_d[i] = 1'b1;
						out_d[i] = 1'b0;
						otim_d[i] = 16'h0;
					end else if (tick && pend_q[i]) begin
						if (otim_q[i] + 16'h1 >= out_cfg_q[i][31:16]) begin
							pend_d[i] = 1'b0;
							out_d[i] = 1'b1;
							otim_d[i] = 16'h0;
						end else begin
							otim_d[i] = otim_q[i] + 16'h1;
						end
					end else if (tick && out_q[i]) begin
						if (otim_q[i] + 16'h1 >= {4'h0, out_cfg_q[i][15:4]}) begin
							out_d[i] = 1'b0;
						end else begin
							otim_d[i] = otim_q[i] + 16'h1;
						end
					end
				end
				default: begin
					out_d[i] = 1'b0;
					pend_d[i] = 1'b0;
				end
			endcase
		end
	end

	always_comb begin
		aw_hold_d = aw_hold_q;
		w_hold_d = w_hold_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		arready_d = !rvalid_q && !rd_fire;
		ctrl_d = ctrl_q;
		in_cfg_d = in_cfg_q;
		out_cfg_d = out_cfg_q;
		mask_d = mask_q;
		sel_d = sel_q;
		irq_st_d = irq_st_q;
		if (S_AXI_AWVALID && !aw_hold_q) begin
			aw_hold_d = 1'b1;
			awaddr_d = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && !w_hold_q) begin
			w_hold_d = 1'b1;
			wdata_d = S_AXI_WDATA;
			wstrb_d = S_AXI_WSTRB;
		end
		if (wr_fire) begin
			aw_hold_d = 1'b0;
			w_hold_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = addr_ok(awaddr_q) ? tio_pkg::RESP_OKAY : tio_pkg::RESP_SLVERR;
			case (awaddr_q)
				tio_pkg::ADDR_CTRL: ctrl_d = merge(ctrl_q, wdata_q, wstrb_q);
				tio_pkg::ADDR_IN0: in_cfg_d[0] = merge(in_cfg_q[0], wdata_q, wstrb_q);
				tio_pkg::ADDR_IN1: in_cfg_d[1] = merge(in_cfg_q[1], wdata_q, wstrb_q);
				tio_pkg::ADDR_OUT0: out_cfg_d[0] = merge(out_cfg_q[0], wdata_q, wstrb_q);
				tio_pkg::ADDR_OUT1: out_cfg_d[1] = merge(out_cfg_q[1], wdata_q, wstrb_q);
				tio_pkg::ADDR_MASK: mask_d = wstrb_q[0] ? wdata_q[3:0] : mask_q;
				tio_pkg::ADDR_RES: sel_d = wstrb_q[0] ? wdata_q[NUM_TYPES-1:0] : sel_q;
				default: ;
			endcase
		end else if (bvalid_q && S_AXI_BREADY) begin
			bvalid_d = 1'b0;
		end
		if (rd_fire) begin
			rvalid_d = 1'b1;
			rresp_d = addr_ok(S_AXI_ARADDR) ? tio_pkg::RESP_OKAY : tio_pkg::RESP_SLVERR;
			case (S_AXI_ARADDR)
				tio_pkg::ADDR_CTRL: rdata_d = ctrl_q;
				tio_pkg::ADDR_IN0: rdata_d = in_cfg_q[0];
				tio_pkg::ADDR_IN1: rdata_d = in_cfg_q[1];
				tio_pkg::ADDR_OUT0: rdata_d = out_cfg_q[0];
				tio_pkg::ADDR_OUT1: rdata_d = out_cfg_q[1];
				tio_pkg::ADDR_STAT: rdata_d = {26'h0, out_q, filt_q, acq_q, level_src_q};
				tio_pkg::ADDR_IRQ: rdata_d = {28'h0, irq_st_q};
				tio_pkg::ADDR_MASK: rdata_d = {28'h0, mask_q};
				tio_pkg::ADDR_RES: rdata_d = 32'(sel_q);
				default: rdata_d = 32'h0;
			endcase
			if (S_AXI_ARADDR == tio_pkg::ADDR_IRQ) begin
				irq_st_d = 4'h0;
			end
		end else if (rvalid_q && S_AXI_RREADY) begin
			rvalid_d = 1'b0;
		end
		// Events are applied after the read clear so a same-cycle event is kept.
		irq_st_d = irq_st_d | {trig_start && !acq_q, miss_q, fault_q, success_q};
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			tick_cnt_q <= 32'h0;
			sync1_q <= 2'h0;
			sync2_q <= 2'h0;
			filt_q <= 2'h0;
			filt_prev_q <= 2'h0;
			deb_cnt_q <= '{8'h0, 8'h0};
			acq_q <= 1'b0;
			level_src_q <= 1'b0;
			acq_ms_q <= 16'h0;
			ev_pulse_q <= 2'h0;
			success_q <= 1'b0;
			fault_q <= 1'b0;
			miss_q <= 1'b0;
			pend_q <= 2'h0;
			out_q <= 2'h0;
			otim_q <= '{16'h0, 16'h0};
			ctrl_q <= {16'h03E8, 16'h0};
			in_cfg_q <= '{{16'h0, tio_pkg::DEBOUNCE_RST, 8'h0}, {16'h0, tio_pkg::DEBOUNCE_RST, 8'h0}};
			out_cfg_q <= '{{tio_pkg::DELAY_RST, tio_pkg::DURATION_RST[11:0], 4'h0},
				{tio_pkg::DELAY_RST, tio_pkg::DURATION_RST[11:0], 4'h0}};
			irq_st_q <= 4'h0;
			mask_q <= 4'h0;
			sel_q <= '1;
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= 8'h0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
			rvalid_q <= 1'b0;
			rresp_q <= 2'h0;
			rdata_q <= 32'h0;
			arready_q <= 1'b0;
			IRQ <= 1'b0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
			sync1_q <= TRIG_IN;
			sync2_q <= sync1_q;
			filt_q <= filt_d;
			filt_prev_q <= filt_q;
			deb_cnt_q <= deb_cnt_d;
			acq_q <= acq_d;
			level_src_q <= level_src_d;
			acq_ms_q <= acq_ms_d;
			ev_pulse_q <= ev_pulse_d;
			success_q <= success_d;
			fault_q <= fault_d;
			miss_q <= miss_d;
			pend_q <= pend_d;
			out_q <= out_d;
			otim_q <= otim_d;
			ctrl_q <= ctrl_d;
			in_cfg_q <= in_cfg_d;
			out_cfg_q <= out_cfg_d;
			irq_st_q <= irq_st_d;
			mask_q <= mask_d;
			sel_q <= sel_d;
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			arready_q <= arready_d;
			IRQ <= |(irq_st_d & mask_q);
		end
	end

	assign ACQ_ACTIVE = acq_q;
	assign EVT_OUT = out_q;
	assign S_AXI_AWREADY = !aw_hold_q;
	assign S_AXI_WREADY = !w_hold_q;
	assign S_AXI_BVALID = bvalid_q;
	assign S_AXI_BRESP = bresp_q;
	assign S_AXI_ARREADY = arready_q;
	assign S_AXI_RVALID = rvalid_q;
	assign S_AXI_RRESP = rresp_q;
	assign S_AXI_RDATA = rdata_q;
endmodule : tio_top

// >>> tb/tio_sensor.sv
// Model of the external trigger sensors on the two isolated lines.
// Assumes the bench sets the wanted levels just after a clock edge.
`timescale 1ns/10ps
module tio_sensor (
	input wire logic clk,
	input wire logic [1:0] want,
	input wire logic [1:0] bounce,
	output logic [1:0] line
);
	// A bounce inverts a line while held, so short chatter can be offered.
	always_ff @(posedge clk) begin
		line <= want ^ bounce;
	end
endmodule : tio_sensor

// >>> tb/tio_asserts.sv
// Port checker for the trigger input and event output block.
// Assumes it is bound to the block's top module.
`timescale 1ns/10ps
module tio_asserts #(
	parameter int unsigned NUM_TYPES = 4
) (
	input wire logic CLOCK,
	input wire logic RST_B,
	input wire logic [NUM_TYPES-1:0] DEC_OK,
	input wire logic DEC_DONE,
	input wire logic ACQ_ACTIVE,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0] S_AXI_RRESP,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RST_B);
	AST_GOOD_READ_CLOSES: assert property (ACQ_ACTIVE && DEC_DONE && (&DEC_OK) |->
		##[1:3] !ACQ_ACTIVE) else $error("window stayed open after a good read");
	AST_BVALID_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write response dropped early");
	AST_RVALID_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
		else $error("read response dropped early");
	AST_RDATA_STABLE: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
		$stable(S_AXI_RDATA)) else $error("read data changed while waiting");
	AST_NO_AR_DURING_R: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("read address accepted during a read response");
	AST_READ_ANSWER: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
	AST_WRITE_ANSWER: assert property (S_AXI_AWVALID && S_AXI_WVALID |->
		##[1:4] S_AXI_BVALID) else $error("write answer late");
	AST_BAD_READ: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 8'h20
		|=> S_AXI_RRESP == 2'h2) else $error("unmapped read not refused");
endmodule : tio_asserts

bind tio_top tio_asserts #(.NUM_TYPES(NUM_TYPES)) u_chk (.CLOCK(CLOCK), .RST_B(RST_B),
	.DEC_OK(DEC_OK), .DEC_DONE(DEC_DONE), .ACQ_ACTIVE(ACQ_ACTIVE),
	.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
	.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));

// >>> tb/tio_top_test.sv
// Self-checking bench for the trigger input and event output block.
// Assumes one 50 MHz clock and register access over AXI4-Lite.
`timescale 1ns/10ps
module tio_top_test;
	logic clk = 1'h0;
	logic rst_b = 1'h0;
	logic [1:0] want = 2'h3;
	logic [1:0] bounce = 2'h0;
	logic [1:0] trig, r, bresp, rresp, evt;
	logic [3:0] dok = 4'h0;
	logic ddone = 1'h0;
	logic derr = 1'h0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata, d;
	logic awv = 1'h0;
	logic wv = 1'h0;
	logic bready = 1'h0;
	logic arv = 1'h0;
	logic rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, acq, irq, s;
	int mismatches = 0;
	int n_tests = 0;
	int lo, hi;
	always #10 clk = !clk;
	tio_sensor i_sen (.clk(clk), .want(want), .bounce(bounce), .line(trig));
	// Five cycles per tick keeps every millisecond count short.
	tio_top #(.TICK_CYCLES(5)) i_dut (.CLOCK(clk), .RST_B(rst_b), .TRIG_IN(trig), .DEC_OK(dok),
		.DEC_DONE(ddone), .DEC_ERR(derr), .ACQ_ACTIVE(acq), .EVT_OUT(evt), .IRQ(irq),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
	task summarize;
		if (mismatches == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : summarize
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awv <= 1'h1;
		wv <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge clk);
			n++;
			if (awready) awv <= 1'h0;
			if (wready) wv <= 1'h0;
		end while (!bvalid && n < 100);
		r = bresp;
		bready <= 1'h0;
		if (n >= 100) mismatches++;
	endtask : wr
	task rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arv <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge clk);
			n++;
			if (arready) arv <= 1'h0;
		end while (!rvalid && n < 100);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
		if (n >= 100) mismatches++;
	endtask : rd
	task wacq(input logic v, input int lim);
		int n;
		n = 0;
		while (acq !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk(32'(acq), 32'(v));
	endtask : wacq
	task dec(input logic [3:0] ok);
		@(posedge clk);
		dok <= ok;
		ddone <= 1'h1;
		@(posedge clk);
		ddone <= 1'h0;
	endtask : dec
	task pw(input int i);
		lo = 0;
		hi = 0;
		while (!evt[i] && lo < 100) begin
			@(posedge clk);
			lo++;
		end
		while (evt[i] && hi < 100) begin
			@(posedge clk);
			hi++;
		end
	endtask : pw
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		rd(tio_pkg::ADDR_IN1);
		chk(d, 32'h0000_0200);
		rd(tio_pkg::ADDR_CTRL);
		chk(d, 32'h03E8_0000);
		chk(32'(evt), 32'h0);
		rd(8'h24);
		chk(32'(r), 32'(tio_pkg::RESP_SLVERR));
		wr(tio_pkg::ADDR_IN0, 32'h0000_0203);
		want <= 2'h2;
		repeat (40) @(posedge clk);
		chk(32'(acq), 32'h0);
		want <= 2'h3;
		wr(tio_pkg::ADDR_CTRL, 32'h0004_0003);
		wr(tio_pkg::ADDR_OUT0, 32'h0003_0022);
		bounce <= 2'h1;
		@(posedge clk);
		bounce <= 2'h0;
		repeat (40) @(posedge clk);
		chk(32'(acq), 32'h0);
		want <= 2'h2;
		wacq(1'h1, 60);
		want <= 2'h3;
		wacq(1'h0, 60);
		rd(tio_pkg::ADDR_IRQ);
		wr(tio_pkg::ADDR_MASK, 32'h1);
		want <= 2'h2;
		wacq(1'h1, 60);
		dec(4'h7);
		repeat (5) @(posedge clk);
		chk(32'(acq), 32'h1);
		chk(32'(irq), 32'h0);
		dec(4'hF);
		wacq(1'h0, 5);
		pw(0);
		chk(32'(lo >= 8 && lo <= 22), 32'h1);
		chk(32'(hi >= 5 && hi <= 15), 32'h1);
		chk(32'(irq), 32'h1);
		rd(tio_pkg::ADDR_IRQ);
		chk(d, 32'h9);
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h0);
		want <= 2'h3;
		wr(tio_pkg::ADDR_IN0, 32'h0000_0200);
		// Each polarity starts from its idle level so only the wanted change can fire.
		for (int p = 1; p < 5; p++) begin
			s = (p == 2 || p == 3);
			want[1] <= s;
			repeat (30) @(posedge clk);
			wr(tio_pkg::ADDR_IN1, 32'h0000_0200 | 32'(p));
			want[1] <= !s;
			wacq(1'h1, 60);
			dec(4'hF);
			wacq(1'h0, 5);
		end
		want <= 2'h3;
		wr(tio_pkg::ADDR_IN1, 32'h0000_0202);
		wr(tio_pkg::ADDR_OUT1, 32'h0001_0044);
		want <= 2'h1;
		wacq(1'h1, 60);
		wacq(1'h0, 40);
		pw(1);
		chk(32'(lo <= 14), 32'h1);
		chk(32'(hi >= 15 && hi <= 25), 32'h1);
		want <= 2'h3;
		wr(tio_pkg::ADDR_OUT1, 32'h1);
		repeat (40) @(posedge clk);
		chk(32'(evt[1]), 32'h1);
		wr(tio_pkg::ADDR_OUT1, 32'h0);
		repeat (3) @(posedge clk);
		chk(32'(evt[1]), 32'h0);
		summarize();
	end
	initial begin
		#300000;
		mismatches++;
		summarize();
	end
endmodule : tio_top_test
